/* File: uss_shifter.sv */
// Purpose: universal serial unit core: shifter, counter, clock hold
// Assumes: cpu strobes are one-cycle pulses on clk
// Notes: all outputs registered; pins synchronised before use
//
// Contract
// RL1 - CPU-accessible 8-bit shift register, no buffering
// RL2 - top bit drives pin chosen by mode
// RL3 - output latch changes opposite sampling edge
// RL4 - input always sampled from data-in pin
// RL5 - CPU-accessible 4-bit counter with overflow
// RL6 - shifter and counter share clock source
// RL7 - external clock counts both edges
// RL8 - three clock sources: pin, timer, software
// RL9 - start interrupt and clock-line wait states
// RL10 - three-wire is SPI mode 0/1
// RL11 - master toggles clock by port or strobe
// RL12 - polarity select swaps sample/shift edges
// RL13 - sixteen edges overflow a byte, wakes idle
// RL14 - peers set up data half cycle early
// RL15 - strobes alone reach half system clock
// RL16 - two-wire bus, no slew or filtering
// RL17 - master clocks, slave holds clock line
// RL18 - two-wire shifting on falling edges
// RL19 - master checks clock actually released
// RL20 - data falling while clock high starts
// RL21 - hold clock low after start, until cleared
// RL22 - master drives data low via bit 7
// RL23 - overflow flag sets on wrap, write-one clears
// RL24 - clearing overflow releases two-wire hold
// RL25 - start flag write-one clears, releases hold
// RL26 - CPU write beats simultaneous shift
`include "uss_defines.svh"
module uss_shifter (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [1:0]  wire_mode,
	input  wire logic        external_clock_select,
	input  wire logic        clock_polarity_select,
	input  wire logic        software_shift_strobe,
	input  wire logic        clock_toggle_strobe,
	input  wire logic        timer_match,
	input  wire logic        data_wr,
	input  wire logic [7:0]  data_wdata,
	input  wire logic        cnt_wr,
	input  wire logic [3:0]  cnt_wdata,
	input  wire logic        ovf_clear,
	input  wire logic        start_clear,
	input  wire logic        port_clock_out,
	input  wire logic        port_data_out,
	input  wire logic        port_clock_dir,
	input  wire logic        port_data_dir,
	input  wire logic        serial_input_pin,
	input  wire logic        serial_clock_pin,
	output logic [7:0]       serial_shift_register,
	output logic [3:0]       counter_value,
	output logic             counter_overflow_flag,
	output logic             start_condition_flag,
	output logic             idle_wake,
	output logic             data_out_pin,
	output logic             data_out_oe,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             scl_out,
	output logic             scl_oe
);
	uss_sync_if sync ();

	uss_edge u_edge (
		.clk     (clk),
		.rst     (rst),
		.sck_pin (serial_clock_pin),
		.sda_pin (serial_input_pin),
		.sync    (sync)
	);

	uss_pkg::uss_byte_t data;
	uss_pkg::uss_cnt_t  cnt;
	uss_pkg::uss_hold_e hold_state;
	logic               ovf;
	logic               start;
	logic               out_latch;
	logic               clk_toggle;
	logic               sample_bit;
	logic               wake;

	// software clock toggle drives the clock pin level via port path
	wire two_wire   = wire_mode == `USS_WM_TWO;
	wire three_wire = wire_mode == `USS_WM_THREE;

	// pin edges; polarity picks which edge samples [RL12]
	wire edge_sample = clock_polarity_select ? sync.sck_fall : sync.sck_rise;
	wire edge_shift  = clock_polarity_select ? sync.sck_rise : sync.sck_fall;
	wire ext_edge    = sync.sck_rise | sync.sck_fall;

	// clock source select: pin, timer or software [RL8]
	wire int_tick  = external_clock_select ? 1'b0
		: (clock_polarity_select ? timer_match : software_shift_strobe);
	// external: counter counts every edge [RL7]
	wire cnt_tick  = external_clock_select
		? (ext_edge | clock_toggle_strobe & 1'b0) : int_tick;
	// external clock in two-wire shifts on falling edges only [RL18]
	wire ext_shift = two_wire ? sync.sck_fall : edge_shift;
	wire shift_tick = external_clock_select ? ext_shift : int_tick;

	// common source steps shifter and counter together [RL6]
	wire [4:0] cnt_sum = {1'b0, cnt} + 5'h01;
	wire       wrap    = cnt_tick & (cnt == `USS_CNT_TOP);

	// start: data falls while clock held high [RL20]
	wire start_det = two_wire & sync.sda_fall & sync.sck;

	// clock held low by slave logic [RL9] [RL17]
	wire hold_low  = two_wire & ((hold_state == uss_pkg::uss_hold_low) | ovf);

	// sample the data-in pin regardless of mode [RL4]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sample_bit <= 1'b0;
		end else if (external_clock_select & edge_sample) begin
			sample_bit <= sync.sda;
		end else if (~external_clock_select) begin
			sample_bit <= sync.sda;
		end
	end

	// cpu write wins over a shift in the same cycle [RL26] [RL1]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data <= `USS_DATA_RESET;
		end else if (data_wr) begin
			data <= data_wdata;
		end else if (shift_tick) begin
			data <= {data[6:0], sample_bit};
		end
	end

	// counter: cpu writes, source increments [RL5] [RL13]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= `USS_CNT_RESET;
		end else if (cnt_wr) begin
			cnt <= cnt_wdata;
		end else if (cnt_tick) begin
			cnt <= cnt_sum[3:0];
		end
	end

	// overflow flag: set beats clear [RL23] [RL24]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovf <= 1'b0;
		end else if (wrap) begin
			ovf <= 1'b1;
		end else if (ovf_clear) begin
			ovf <= 1'b0;
		end
	end

	// start flag: set beats clear [RL25]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start <= 1'b0;
		end else if (start_det) begin
			start <= 1'b1;
		end else if (start_clear) begin
			start <= 1'b0;
		end
	end

	// hold after start: arm, then pull low at next fall [RL21]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_state <= uss_pkg::uss_hold_idle;
		end else begin
			case (hold_state)
				uss_pkg::uss_hold_idle: begin
					if (start_det)
						hold_state <= uss_pkg::uss_hold_armed;
				end
				uss_pkg::uss_hold_armed: begin
					if (~two_wire | start_clear & ~start_det)
						hold_state <= uss_pkg::uss_hold_idle;
					else if (sync.sck_fall)
						hold_state <= uss_pkg::uss_hold_low;
				end
				uss_pkg::uss_hold_low: begin
					if (~two_wire | start_clear & ~start_det)
						hold_state <= uss_pkg::uss_hold_idle;
				end
				default: hold_state <= uss_pkg::uss_hold_idle;
			endcase
		end
	end

	// output latch open while the clock rests at its shift level, so the
	// pin only moves after the shift edge, never on the sample edge [RL3]
	wire latch_open = ~external_clock_select
		| (clock_polarity_select ? sync.sck : ~sync.sck)
		| ~(three_wire | two_wire);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_latch <= 1'b0;
		end else if (latch_open) begin
			out_latch <= data_wr ? data_wdata[7] : data[7];
		end
	end

	// clock toggle strobe flips clock output [RL11] [RL15]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clk_toggle <= 1'b0;
		end else if (clock_toggle_strobe) begin
			clk_toggle <= ~clk_toggle;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake <= 1'b0;
		end else begin
			wake <= ovf; // [RL13]
		end
	end

	// bit 7 to data-out in three-wire, to data line in two-wire [RL2]
	// [RL10] three-wire has no select pin; [RL16] no filtering
	// [RL22] open-drain data line low when bit 7 or port bit is 0
	wire next_do_oe   = three_wire & port_data_dir;
	wire next_sda_oe  = two_wire & port_data_dir & ~(out_latch & port_data_out);
	wire scl_level    = port_clock_out ^ clk_toggle;
	wire next_scl_oe  = hold_low | port_clock_dir & (~two_wire | ~scl_level);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out_pin <= 1'b0;
			data_out_oe  <= 1'b0;
			sda_out      <= 1'b0;
			sda_oe       <= 1'b0;
			scl_out      <= 1'b0;
			scl_oe       <= 1'b0;
		end else begin
			data_out_pin <= out_latch;
			data_out_oe  <= next_do_oe;
			sda_out      <= 1'b0;
			sda_oe       <= next_sda_oe;
			scl_out      <= two_wire ? 1'b0 : scl_level;
			scl_oe       <= next_scl_oe;
		end
	end

	assign serial_shift_register = data;
	assign counter_value         = cnt;
	assign counter_overflow_flag = ovf;
	assign start_condition_flag  = start;
	assign idle_wake             = wake;

	a_ovf_sticky: assert property (@(posedge clk) disable iff (rst) // [RL23]
		ovf & ~ovf_clear |=> ovf)
		else $error("overflow flag dropped without clear");
	a_wrap_sets: assert property (@(posedge clk) disable iff (rst) // [RL23]
		wrap |=> ovf)
		else $error("wrap did not set overflow");
	a_write_wins: assert property (@(posedge clk) disable iff (rst) // [RL26]
		data_wr |=> data == $past(data_wdata))
		else $error("cpu write lost");
	a_shift_in: assert property (@(posedge clk) disable iff (rst) // [RL1]
		shift_tick & ~data_wr |=> data == {$past(data[6:0]), $past(sample_bit)})
		else $error("shift wrong");
	a_cnt_step: assert property (@(posedge clk) disable iff (rst) // [RL6]
		cnt_tick & ~cnt_wr |=> cnt == $past(cnt) + 4'h1)
		else $error("counter did not step");
	a_start_set: assert property (@(posedge clk) disable iff (rst) // [RL20]
		start_det |=> start)
		else $error("start not flagged");
	a_start_hold: assert property (@(posedge clk) disable iff (rst) // [RL21]
		hold_state == uss_pkg::uss_hold_low & two_wire |=> scl_oe)
		else $error("clock not held after start");
	a_ovf_hold: assert property (@(posedge clk) disable iff (rst) // [RL24]
		two_wire & ovf |=> scl_oe)
		else $error("clock not held on overflow");
	a_three_oe: assert property (@(posedge clk) disable iff (rst) // [RL2]
		~three_wire |=> ~data_out_oe)
		else $error("data out driven outside three-wire");
endmodule

/* File: uss_defines.svh */
// Purpose: constants for the universal serial shifter
// Assumes: clk at 50 MHz
// Notes: wire mode and clock source encodings live here
`ifndef USS_DEFINES_SVH
`define USS_DEFINES_SVH
`define USS_WM_NONE      2'h0
`define USS_WM_THREE     2'h1
`define USS_WM_TWO       2'h2
`define USS_CS_SOFT      2'h0
`define USS_CS_TIMER     2'h1
`define USS_CS_EXT       2'h2
`define USS_DATA_RESET   8'h00
`define USS_CNT_RESET    4'h0
`define USS_CNT_TOP      4'hf
`define USS_CLK_MHZ      50
`endif

/* File: uss_pkg.sv */
// Purpose: types for the universal serial shifter
// Assumes: nothing
// Notes: encodings match the defines header
package uss_pkg;
	typedef logic [7:0] uss_byte_t;
	typedef logic [3:0] uss_cnt_t;
	typedef enum logic [1:0] {
		uss_hold_idle  = 2'b00,
		uss_hold_armed = 2'b01,
		uss_hold_low   = 2'b10
	} uss_hold_e;
endpackage

/* File: uss_sync_if.sv */
// Purpose: synchronised pin levels and edge events between modules
// Assumes: single clk domain
// Notes: produced by the edge module, consumed by the top
interface uss_sync_if;
	logic sck;
	logic sck_rise;
	logic sck_fall;
	logic sda;
	logic sda_fall;
	modport prod (output sck, sck_rise, sck_fall, sda, sda_fall);
	modport cons (input sck, sck_rise, sck_fall, sda, sda_fall);
endinterface

/* File: uss_edge.sv */
// Purpose: two-flop synchronisers and edge detection for clock and data
// Assumes: pins asynchronous to clk
// Notes: edges come from the second and third stage only
module uss_edge (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sck_pin,
	input  wire logic sda_pin,
	uss_sync_if.prod  sync
);
	logic [2:0] sck_q;
	logic [2:0] sda_q;
	logic [2:0] fill;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_q <= 3'h7;
			sda_q <= 3'h7;
			fill  <= 3'h0;
		end else begin
			sck_q <= {sck_q[1:0], sck_pin};
			sda_q <= {sda_q[1:0], sda_pin};
			fill  <= {fill[1:0], 1'b1};
		end
	end

	// edges masked until every stage holds a real pin sample, so the
	// reset value can never fake an edge against an idle-low pin
	wire primed = fill[2];

	assign sync.sck      = sck_q[1];
	assign sync.sck_rise = primed & sck_q[1] & ~sck_q[2];
	assign sync.sck_fall = primed & ~sck_q[1] & sck_q[2];
	assign sync.sda      = sda_q[1];
	assign sync.sda_fall = primed & ~sda_q[1] & sda_q[2];
endmodule

/* File: uss_peer.sv */
// Purpose: remote serial master driving clock and data toward the shifter
// Assumes: 160 ns link clock period, far slower than clk
// Notes: tb calls the tasks hierarchically; clock stands still between frames
module uss_peer (
	output logic      sck,
	output logic      sdo,
	input  wire logic sdi,
	input  wire logic scl_line
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sck = 1'b0;
		sdo = 1'b0;
	end
	task automatic park(input logic pol);
		sck = pol;
	endtask
	// device output is read just before each shift edge: its pin lags the
	// link clock by the synchroniser delay, so the sample edge would race
	task automatic xfer(input logic [7:0] tx, input logic pol,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			sdo = tx[i];
			#80 sck = ~pol;
			#80 rx = {rx[6:0], sdi};
			sck = pol;
		end
		#80 sdo = ~sdo;
	endtask
	task automatic start_cond();
		sck = 1'b1;
		sdo = 1'b1;
		// a slave may still stretch the line low; go on once it is high
		#160 wait (scl_line);
		sdo = 1'b0;
		#160 sck = 1'b0;
	endtask
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the universal serial shifter
// Assumes: clk 50 MHz, peer link clock 160 ns
// Notes: inputs change on the falling edge, results read there too
`include "uss_defines.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk, rst, ext_sel, pol_sel, sw_stb, tog_stb, tmr;
	logic       data_wr, cnt_wr, ovf_clr, st_clr, p_ddir;
	logic [1:0] mode;
	logic [7:0] wdata, rx, sr;
	logic [3:0] cwdata, cnt;
	logic       ovf, stf, wake, dout, dout_oe, sda_o, sda_oe, scl_o, scl_oe;
	wire        peer_sck, peer_sdo, peer_sdi, sin_pin, sck_pin;
	int         err_total, total_checks;
	// open-drain lines: either party pulling low wins
	assign sin_pin = (mode == `USS_WM_TWO) ? (peer_sdo & ~sda_oe) : peer_sdo;
	assign sck_pin = (mode == `USS_WM_TWO) ? (peer_sck & ~scl_oe) : peer_sck;
	// undriven data line shows the inverse rather than a stale value
	assign peer_sdi = dout_oe ? dout : ~dout;
	uss_peer i_peer (.sck(peer_sck), .sdo(peer_sdo), .sdi(peer_sdi),
		.scl_line(sck_pin));
	uss_shifter i_dut (.clk(clk), .rst(rst), .wire_mode(mode),
		.external_clock_select(ext_sel), .clock_polarity_select(pol_sel),
		.software_shift_strobe(sw_stb), .clock_toggle_strobe(tog_stb),
		.timer_match(tmr), .data_wr(data_wr), .data_wdata(wdata),
		.cnt_wr(cnt_wr), .cnt_wdata(cwdata), .ovf_clear(ovf_clr),
		.start_clear(st_clr), .port_clock_out(1'b0), .port_data_out(1'b1),
		.port_clock_dir(1'b0), .port_data_dir(p_ddir),
		.serial_input_pin(sin_pin), .serial_clock_pin(sck_pin),
		.serial_shift_register(sr), .counter_value(cnt),
		.counter_overflow_flag(ovf), .start_condition_flag(stf),
		.idle_wake(wake), .data_out_pin(dout), .data_out_oe(dout_oe),
		.sda_out(sda_o), .sda_oe(sda_oe), .scl_out(scl_o), .scl_oe(scl_oe));
	always #10 clk = ~clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic t_reset();
		chk(sr, 8'h00);
		chk(8'(cnt), 8'h00);
		chk(8'({ovf, stf, scl_oe}), 8'h00);
	endtask
	task automatic t_write();
		wdata = 8'h5a;
		cwdata = 4'h9;
		data_wr = 1'b1;
		cnt_wr = 1'b1;
		cyc(1);
		data_wr = 1'b0;
		cnt_wr = 1'b0;
		chk(sr, 8'h5a);
		chk(8'(cnt), 8'h09);
		wdata = 8'hc3;
		data_wr = 1'b1;
		sw_stb = 1'b1;
		cyc(1);
		data_wr = 1'b0;
		sw_stb = 1'b0;
		chk(sr, 8'hc3);
		chk(8'(cnt), 8'h0a);
	endtask
	task automatic t_soft();
		wdata = 8'h81;
		cwdata = 4'h0;
		pulse(data_wr);
		pulse(cnt_wr);
		sw_stb = 1'b1;
		cyc(1);
		chk(sr, 8'h02);
		cyc(14);
		chk(8'({ovf, cnt}), 8'h0f);
		cyc(1);
		sw_stb = 1'b0;
		chk(8'({ovf, cnt}), 8'h10);
		cyc(1);
		chk(8'(wake), 8'h01);
		cyc(3);
		chk(8'(ovf), 8'h01);
		pulse(ovf_clr);
		chk(8'(ovf), 8'h00);
	endtask
	task automatic t_timer();
		pol_sel = 1'b1;
		pulse(sw_stb);
		chk(8'(cnt), 8'h00);
		repeat (3) pulse(tmr);
		chk(8'(cnt), 8'h03);
	endtask
	task automatic t_spi(input logic pol);
		mode = `USS_WM_THREE;
		ext_sel = 1'b1;
		pol_sel = pol;
		p_ddir = 1'b1;
		i_peer.park(pol);
		cyc(6);
		wdata = 8'hb4;
		cwdata = 4'h0;
		data_wr = 1'b1;
		cnt_wr = 1'b1;
		ovf_clr = 1'b1;
		cyc(1);
		data_wr = 1'b0;
		cnt_wr = 1'b0;
		ovf_clr = 1'b0;
		cyc(2);
		chk(8'({dout_oe, dout}), 8'h03);
		i_peer.xfer(8'hc5 ^ {8{pol}}, pol, rx);
		cyc(10);
		chk(sr, 8'hc5 ^ {8{pol}});
		chk(rx, 8'hb4);
		chk(8'({ovf, cnt}), 8'h10);
	endtask
	task automatic t_toggle();
		logic s0;
		ext_sel = 1'b0;
		pol_sel = 1'b0;
		s0 = scl_o;
		pulse(tog_stb);
		cyc(2);
		chk(8'(scl_o), {7'h00, ~s0});
		pulse(tog_stb);
		cyc(2);
		chk(8'(scl_o), 8'(s0));
	endtask
	task automatic t_two();
		mode = `USS_WM_TWO;
		p_ddir = 1'b0;
		pulse(st_clr);
		pulse(ovf_clr);
		chk(8'(stf), 8'h00);
		i_peer.start_cond();
		cyc(6);
		chk(8'({stf, scl_oe, scl_o}), 8'h06);
		pulse(st_clr);
		cyc(1);
		chk(8'({stf, scl_oe}), 8'h00);
		cwdata = 4'hf;
		pulse(cnt_wr);
		pulse(sw_stb);
		chk(8'({ovf, scl_oe}), 8'h03);
		pulse(ovf_clr);
		chk(8'({ovf, scl_oe}), 8'h00);
		p_ddir = 1'b1;
		wdata = 8'h00;
		pulse(data_wr);
		chk(8'({sda_oe, sda_o}), 8'h02);
		wdata = 8'h80;
		pulse(data_wr);
		chk(8'({sda_oe, sda_o}), 8'h00);
	endtask
	initial begin
		{clk, ext_sel, pol_sel, sw_stb, tog_stb, tmr, p_ddir} = 7'h00;
		{data_wr, cnt_wr, ovf_clr, st_clr} = 4'h0;
		{mode, wdata, cwdata} = 14'h0000;
		err_total = 0;
		total_checks = 0;
		rst = 1'b1;
		cyc(8);
		rst = 1'b0;
		cyc(1);
		t_reset();
		t_write();
		t_soft();
		t_timer();
		t_spi(1'b0);
		t_spi(1'b1);
		t_toggle();
		t_two();
		end_of_test();
	end
	initial begin
		#200000;
		err_total++;
		end_of_test();
	end
endmodule
